// ### core/tcpwm_pkg.sv
package tcpwm_pkg;
    // ------------------------------------------------------------
    // Widths
    // ------------------------------------------------------------
    localparam int CNT_W    = 16;
    localparam int DB_W     = 8;
    localparam int CLKSEL_W = 2;
    localparam int NUM_CLK  = 4;

    localparam logic [CNT_W-1:0] CNT_ZERO  = 16'h0000;
    localparam logic [CNT_W-1:0] CNT_ONE   = 16'h0001;
    localparam logic [DB_W-1:0]  DB_ZERO   = 8'h00;
    localparam logic [DB_W-1:0]  DB_ONE    = 8'h01;

    // ------------------------------------------------------------
    // Modes
    // ------------------------------------------------------------
    typedef enum logic [1:0] {
        TCPWM_RUN_FREE,
        TCPWM_RUN_ONESHOT,
        TCPWM_RUN_GATED
    } tcpwm_run_e;

    typedef enum logic [2:0] {
        TCPWM_CMP_LT,
        TCPWM_CMP_LTE,
        TCPWM_CMP_EQ,
        TCPWM_CMP_GTE,
        TCPWM_CMP_GT
    } tcpwm_cmp_e;
endpackage

// ### core/tcpwm_deadband.sv
`timescale 1ns/1ps
// Complementary pair with deadband; kill forces both inactive
module tcpwm_deadband (
    input  wire logic                          mclk_in,
    input  wire logic                          resetn_in,
    input  wire logic                          pwm_in,
    input  wire logic                          kill_in,
    input  wire logic [tcpwm_pkg::DB_W-1:0]    deadband_in,
    output logic                               pwm_hi_out,
    output logic                               pwm_lo_out
);
    logic                         prev_ff;
    logic                         nxt_prev;
    logic [tcpwm_pkg::DB_W-1:0]   dead_ff;
    logic [tcpwm_pkg::DB_W-1:0]   nxt_dead;
    logic                         hi_ff;
    logic                         nxt_hi;
    logic                         lo_ff;
    logic                         nxt_lo;

    always_comb begin
        nxt_prev = pwm_in;
        nxt_dead = dead_ff;
        if (pwm_in != prev_ff) begin
            nxt_dead = deadband_in;
        end else if (dead_ff != tcpwm_pkg::DB_ZERO) begin
            nxt_dead = dead_ff - tcpwm_pkg::DB_ONE;
        end
        // Both low on any edge and while the dead timer runs
        if (kill_in || (pwm_in != prev_ff) || (dead_ff != tcpwm_pkg::DB_ZERO && deadband_in != tcpwm_pkg::DB_ZERO)) begin
            nxt_hi = 1'b0;
            nxt_lo = 1'b0;
        end else begin
            nxt_hi = pwm_in;
            nxt_lo = ~pwm_in;
        end
        if (kill_in) begin
            nxt_hi = 1'b0; //RULE11
            nxt_lo = 1'b0;
        end
    end

    always_ff @(posedge mclk_in) begin
        if (!resetn_in) begin
            prev_ff <= 1'b0;
            dead_ff <= tcpwm_pkg::DB_ZERO;
            hi_ff   <= 1'b0;
            lo_ff   <= 1'b0;
        end else begin
            prev_ff <= nxt_prev;
            dead_ff <= nxt_dead;
            hi_ff   <= nxt_hi; //RULE13
            lo_ff   <= nxt_lo;
        end
    end

    assign pwm_hi_out = hi_ff;
    assign pwm_lo_out = lo_ff;

    // ------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------
    property p_never_both;
        @(posedge mclk_in) disable iff (!resetn_in) !(hi_ff && lo_ff);
    endproperty
    a_never_both: assert property (p_never_both) else $error("both pwm outputs active"); //RULE13

    property p_kill;
        @(posedge mclk_in) disable iff (!resetn_in) kill_in |=> (!hi_ff && !lo_ff);
    endproperty
    a_kill: assert property (p_kill) else $error("kill did not force outputs off"); //RULE11

    property p_edge_dead;
        @(posedge mclk_in) disable iff (!resetn_in) (pwm_in != prev_ff) |=> (!hi_ff && !lo_ff);
    endproperty
    a_edge_dead: assert property (p_edge_dead) else $error("no deadband at pwm edge"); //RULE13

    c_kill: cover property (@(posedge mclk_in) disable iff (!resetn_in) kill_in ##1 !kill_in);
endmodule

// ### core/tcpwm_timer.sv
`timescale 1ns/1ps
// ------------------------------------------------------------
// Notes on behaviour
// ------------------------------------------------------------
//Notes on behaviour
//RULE1: Sixteen-bit counter, decrements only, one step per enabled selected clock edge.
//RULE2: Counting clock chosen from several sources by a select input.
//RULE3: Comparator count versus compare value: LT, LTE, EQ, GTE or GT.
//RULE4: Period loaded on start, on reset input and on terminal count.
//RULE5: Interrupt request from terminal count, compare true or capture, each maskable.
//RULE6: Run behaviour is free running, one shot or enable gated.
//RULE7: One shot stops at end of period until started again.
//RULE8: Gated mode decrements only while enable is high.
//RULE9: Capture event latches the full live count.
//RULE10: Reset and capture inputs come from outside logic.
//RULE11: Kill forces comparator outputs inactive while asserted.
//RULE12: Compare and terminal count outputs, compare optionally inverted.
//RULE13: Complementary PWM pair separated by programmable deadband.
//RULE14: Terminal count lasts one count at zero; reload on next count.
//RULE15: Live count readable any time without disturbing counting.
module tcpwm_timer (
    input  wire logic                              mclk_in,
    input  wire logic                              resetn_in,
    input  wire logic [tcpwm_pkg::NUM_CLK-1:0]     clk_src_in,
    input  wire logic [tcpwm_pkg::CLKSEL_W-1:0]    clk_sel_in,
    input  wire logic                              start_in,
    input  wire logic                              stop_in,
    input  wire logic                              tmr_reset_in,
    input  wire logic                              capture_in,
    input  wire logic                              enable_in,
    input  wire logic                              kill_in,
    input  wire tcpwm_pkg::tcpwm_run_e             run_mode_in,
    input  wire tcpwm_pkg::tcpwm_cmp_e             cmp_mode_in,
    input  wire logic                              cmp_invert_in,
    input  wire logic [tcpwm_pkg::CNT_W-1:0]       period_in,
    input  wire logic [tcpwm_pkg::CNT_W-1:0]       compare_in,
    input  wire logic [tcpwm_pkg::DB_W-1:0]        deadband_in,
    input  wire logic                              irq_tc_en_in,
    input  wire logic                              irq_cmp_en_in,
    input  wire logic                              irq_cap_en_in,
    output logic [tcpwm_pkg::CNT_W-1:0]            count_out,
    output logic [tcpwm_pkg::CNT_W-1:0]            capture_val_out,
    output logic                                   running_out,
    output logic                                   tc_out,
    output logic                                   cmp_out,
    output logic                                   pwm_hi_out,
    output logic                                   pwm_lo_out,
    output logic                                   irq_out
);
    // ------------------------------------------------------------
    // Input synchronisers
    // ------------------------------------------------------------
    localparam int NSYNC = tcpwm_pkg::NUM_CLK + 4;
    logic [NSYNC-1:0] raw_in;
    logic [NSYNC-1:0] s1_ff;
    logic [NSYNC-1:0] s2_ff;
    logic [NSYNC-1:0] s3_ff;

    assign raw_in = {kill_in, enable_in, capture_in, tmr_reset_in, clk_src_in};

    genvar gi;
    generate
        for (gi = 0; gi < NSYNC; gi++) begin : g_sync
            always_ff @(posedge mclk_in) begin
                if (!resetn_in) begin
                    s1_ff[gi] <= 1'b0;
                    s2_ff[gi] <= 1'b0;
                    s3_ff[gi] <= 1'b0;
                end else begin
                    s1_ff[gi] <= raw_in[gi];
                    s2_ff[gi] <= s1_ff[gi];
                    s3_ff[gi] <= s2_ff[gi];
                end
            end
        end
    endgenerate

    localparam int IX_RST = tcpwm_pkg::NUM_CLK;
    localparam int IX_CAP = tcpwm_pkg::NUM_CLK + 1;
    localparam int IX_EN  = tcpwm_pkg::NUM_CLK + 2;
    localparam int IX_KIL = tcpwm_pkg::NUM_CLK + 3;

    function automatic logic rise(input logic [NSYNC-1:0] now, input logic [NSYNC-1:0] old, input int idx);
        rise = now[idx] & ~old[idx];
    endfunction

    logic sel_edge;
    logic rst_edge;
    logic cap_edge;
    logic en_s;
    logic kill_s;
    assign sel_edge = rise(s2_ff, s3_ff, int'(clk_sel_in)); //RULE2
    assign rst_edge = rise(s2_ff, s3_ff, IX_RST); //RULE10
    assign cap_edge = rise(s2_ff, s3_ff, IX_CAP);
    assign en_s     = s2_ff[IX_EN];
    assign kill_s   = s2_ff[IX_KIL];

    // ------------------------------------------------------------
    // Counter
    // ------------------------------------------------------------
    logic [tcpwm_pkg::CNT_W-1:0] cnt_ff;
    logic [tcpwm_pkg::CNT_W-1:0] nxt_cnt;
    logic [tcpwm_pkg::CNT_W-1:0] cap_ff;
    logic [tcpwm_pkg::CNT_W-1:0] nxt_cap;
    logic                        run_ff;
    logic                        nxt_run;
    logic                        tc_ff;
    logic                        nxt_tc;
    logic                        cmp_ff;
    logic                        nxt_cmp;
    logic                        irq_ff;
    logic                        nxt_irq;
    // Raw compare history, so inversion cannot retrigger the interrupt
    logic                        cmpr_ff;
    logic                        nxt_cmpr;
    logic                        step;
    logic                        cmp_true;

    always_comb begin
        unique case (cmp_mode_in)
            tcpwm_pkg::TCPWM_CMP_LT:  cmp_true = cnt_ff <  compare_in;
            tcpwm_pkg::TCPWM_CMP_LTE: cmp_true = cnt_ff <= compare_in;
            tcpwm_pkg::TCPWM_CMP_EQ:  cmp_true = cnt_ff == compare_in;
            tcpwm_pkg::TCPWM_CMP_GTE: cmp_true = cnt_ff >= compare_in;
            tcpwm_pkg::TCPWM_CMP_GT:  cmp_true = cnt_ff >  compare_in;
            default:                  cmp_true = 1'b0; //RULE3
        endcase
    end

    // Gated mode only counts while enable holds
    assign step = run_ff && sel_edge && ((run_mode_in != tcpwm_pkg::TCPWM_RUN_GATED) || en_s); //RULE8

    always_comb begin
        nxt_cnt = cnt_ff;
        nxt_run = run_ff;
        nxt_tc  = tc_ff;
        nxt_cap = cap_ff;
        if (step) begin
            nxt_tc = 1'b0;
            if (cnt_ff == tcpwm_pkg::CNT_ZERO) begin
                nxt_cnt = period_in; //RULE4
            end else begin
                nxt_cnt = cnt_ff - tcpwm_pkg::CNT_ONE; //RULE1
                if (cnt_ff == tcpwm_pkg::CNT_ONE) begin
                    nxt_tc = 1'b1; //RULE14
                    if (run_mode_in == tcpwm_pkg::TCPWM_RUN_ONESHOT) begin
                        nxt_run = 1'b0; //RULE7
                    end
                end
            end
        end
        if (stop_in) begin
            nxt_run = 1'b0;
        end
        // Restart has priority over counting; start_in also wins over stop, the reset input does not
        if (start_in || rst_edge) begin
            nxt_cnt = period_in; //RULE4
            nxt_tc  = 1'b0;
            if (start_in) begin
                nxt_run = 1'b1;
            end
        end
        if (cap_edge) begin
            nxt_cap = cnt_ff; //RULE9
        end
        nxt_cmp  = cmp_true ^ cmp_invert_in; //RULE12
        nxt_cmpr = cmp_true;
        nxt_irq  = (irq_tc_en_in && nxt_tc && !tc_ff) || (irq_cmp_en_in && cmp_true && !cmpr_ff)
                  || (irq_cap_en_in && cap_edge); //RULE5
    end

    always_ff @(posedge mclk_in) begin
        if (!resetn_in) begin
            cnt_ff <= tcpwm_pkg::CNT_ZERO;
            cap_ff <= tcpwm_pkg::CNT_ZERO;
            run_ff <= 1'b0;
            tc_ff  <= 1'b0;
            cmp_ff <= 1'b0;
            irq_ff <= 1'b0;
            cmpr_ff <= 1'b0;
        end else begin
            cnt_ff <= nxt_cnt;
            cap_ff <= nxt_cap;
            run_ff <= nxt_run; //RULE6
            tc_ff  <= nxt_tc;
            cmp_ff <= nxt_cmp;
            irq_ff <= nxt_irq;
            cmpr_ff <= nxt_cmpr;
        end
    end

    // Live count is a plain register copy; reading never disturbs it
    assign count_out       = cnt_ff; //RULE15
    assign capture_val_out = cap_ff;
    assign running_out     = run_ff;
    assign tc_out          = tc_ff;
    assign cmp_out         = cmp_ff & ~kill_s; //RULE11
    assign irq_out         = irq_ff;

    tcpwm_deadband u_db (
        .mclk_in     (mclk_in),
        .resetn_in   (resetn_in),
        .pwm_in      (cmp_true),
        .kill_in     (kill_s),
        .deadband_in (deadband_in),
        .pwm_hi_out  (pwm_hi_out),
        .pwm_lo_out  (pwm_lo_out)
    );

    // ------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------
    property p_down_only;
        @(posedge mclk_in) disable iff (!resetn_in)
        (step && !start_in && !rst_edge && cnt_ff != tcpwm_pkg::CNT_ZERO)
        |=> (cnt_ff == $past(cnt_ff) - tcpwm_pkg::CNT_ONE);
    endproperty
    a_down_only: assert property (p_down_only) else $error("counter did not decrement"); //RULE1

    property p_hold;
        @(posedge mclk_in) disable iff (!resetn_in)
        (!step && !start_in && !rst_edge) |=> (cnt_ff == $past(cnt_ff));
    endproperty
    a_hold: assert property (p_hold) else $error("counter moved without a step"); //RULE8

    property p_start_load;
        @(posedge mclk_in) disable iff (!resetn_in) (start_in || rst_edge) |=> (cnt_ff == $past(period_in));
    endproperty
    a_start_load: assert property (p_start_load) else $error("period not loaded"); //RULE4

    property p_reload;
        @(posedge mclk_in) disable iff (!resetn_in)
        (step && cnt_ff == tcpwm_pkg::CNT_ZERO && !start_in && !rst_edge) |=> (cnt_ff == $past(period_in));
    endproperty
    a_reload: assert property (p_reload) else $error("no reload after terminal count"); //RULE14

    property p_oneshot;
        @(posedge mclk_in) disable iff (!resetn_in)
        (run_mode_in == tcpwm_pkg::TCPWM_RUN_ONESHOT && step && cnt_ff == tcpwm_pkg::CNT_ONE && !start_in && !rst_edge)
        |=> (!run_ff && tc_ff);
    endproperty
    a_oneshot: assert property (p_oneshot) else $error("one shot did not stop"); //RULE7

    property p_capture;
        @(posedge mclk_in) disable iff (!resetn_in) cap_edge |=> (cap_ff == $past(cnt_ff));
    endproperty
    a_capture: assert property (p_capture) else $error("capture value wrong"); //RULE9

    property p_irq_cap;
        @(posedge mclk_in) disable iff (!resetn_in) (cap_edge && irq_cap_en_in) |=> irq_ff;
    endproperty
    a_irq_cap: assert property (p_irq_cap) else $error("capture interrupt missing"); //RULE5

    property p_kill_cmp;
        @(posedge mclk_in) disable iff (!resetn_in)
        (kill_s && $past(kill_s)) |-> (!cmp_out && !pwm_hi_out && !pwm_lo_out);
    endproperty
    a_kill_cmp: assert property (p_kill_cmp) else $error("compare output active under kill"); //RULE11

    property p_cmp_eq;
        @(posedge mclk_in) disable iff (!resetn_in)
        (cmp_mode_in == tcpwm_pkg::TCPWM_CMP_EQ && !cmp_invert_in)
        |=> (cmp_ff == ($past(cnt_ff) == $past(compare_in)));
    endproperty
    a_cmp_eq: assert property (p_cmp_eq) else $error("equal compare wrong"); //RULE3

    c_tc:      cover property (@(posedge mclk_in) disable iff (!resetn_in) tc_ff);
    c_oneshot: cover property (@(posedge mclk_in) disable iff (!resetn_in) run_ff ##1 !run_ff);
    c_cap:     cover property (@(posedge mclk_in) disable iff (!resetn_in) cap_edge);
endmodule

// ### testbench/tcpwm_fabric.sv
`timescale 1ns/1ps
// ------------------------------------------------------------
// Far-side count clock source
// ------------------------------------------------------------
module tcpwm_fabric #(
    parameter int HALF_NS = 133
) (
    input  wire logic       run_in,
    input  wire logic [1:0] line_in,
    output logic [3:0]      clk_src_out,
    output int              rises_out
);
    logic ph;

    initial begin
        ph = 1'b0;
        rises_out = 0;
    end

    // Parks low between bursts so no stray rise reaches the selector
    always #(HALF_NS) begin
        ph = run_in ? ~ph : 1'b0;
        if (run_in && ph) begin
            rises_out = rises_out + 1;
        end
    end

    assign clk_src_out = {3'h0, ph} << line_in;
endmodule

// ### testbench/timer_counter_pwm_16bit_tb.sv
`timescale 1ns/1ps
module timer_counter_pwm_16bit_tb;
    logic mclk_in = 0, resetn_in = 0, start_in = 0, stop_in = 0, tmr_reset_in = 0, capture_in = 0;
    logic enable_in = 0, kill_in = 0, cmp_invert_in = 0, irq_tc_en_in = 0, irq_cmp_en_in = 0;
    logic irq_cap_en_in = 0, run = 0, tc_q = 0;
    logic [1:0] clk_sel_in = 2'h0, line = 2'h0;
    logic [3:0] clk_src;
    logic [15:0] period_in = 16'h0005, compare_in = 16'h0000, count_out, capture_val_out;
    logic [7:0] deadband_in = 8'h03;
    logic running_out, tc_out, cmp_out, pwm_hi_out, pwm_lo_out, irq_out;
    tcpwm_pkg::tcpwm_run_e run_mode_in = tcpwm_pkg::TCPWM_RUN_FREE;
    tcpwm_pkg::tcpwm_cmp_e cmp_mode_in = tcpwm_pkg::TCPWM_CMP_LT;
    int rises, num_errors = 0, n_compared = 0, cycles = 0, tc_rises = 0, irq_cnt = 0, both_hi = 0;

    tcpwm_timer i_tcpwm_timer (.mclk_in(mclk_in), .resetn_in(resetn_in), .clk_src_in(clk_src),
        .clk_sel_in(clk_sel_in), .start_in(start_in), .stop_in(stop_in), .tmr_reset_in(tmr_reset_in),
        .capture_in(capture_in), .enable_in(enable_in), .kill_in(kill_in), .run_mode_in(run_mode_in),
        .cmp_mode_in(cmp_mode_in), .cmp_invert_in(cmp_invert_in), .period_in(period_in),
        .compare_in(compare_in), .deadband_in(deadband_in), .irq_tc_en_in(irq_tc_en_in),
        .irq_cmp_en_in(irq_cmp_en_in), .irq_cap_en_in(irq_cap_en_in), .count_out(count_out),
        .capture_val_out(capture_val_out), .running_out(running_out), .tc_out(tc_out), .cmp_out(cmp_out),
        .pwm_hi_out(pwm_hi_out), .pwm_lo_out(pwm_lo_out), .irq_out(irq_out));
    tcpwm_fabric i_tcpwm_fabric (.run_in(run), .line_in(line), .clk_src_out(clk_src), .rises_out(rises));

    always #20 mclk_in = ~mclk_in;

    // ------------------------------------------------------------
    // Monitors and timeout
    // ------------------------------------------------------------
    always @(posedge mclk_in) begin
        tc_q <= tc_out;
        if (tc_out === 1'b1 && tc_q !== 1'b1) tc_rises++;
        if (irq_out === 1'b1) irq_cnt++;
        if (pwm_hi_out === 1'b1 && pwm_lo_out === 1'b1) both_hi++;
        cycles++;
        if (cycles == 20000) begin
            num_errors++;
            summarize();
        end
    end

    // ------------------------------------------------------------
    // Helpers
    // ------------------------------------------------------------
    task automatic summarize();
        if (num_errors == 0 && n_compared > 0) $display("Result: passed");
        else $display("Result: failed");
        $finish;
    endtask

    task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
        n_compared++;
        if (seen !== exp) begin
            num_errors++;
            $display("Error t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask

    task automatic cyc(input int n);
        repeat (n) @(negedge mclk_in);
    endtask

    // Source parked before returning; 6 cycles cover the 3-stage sync
    task automatic pulse_src(input int n);
        int goal;
        int guard;
        goal = rises + n;
        guard = 0;
        @(negedge mclk_in);
        run = 1'b1;
        while (rises < goal && guard < 300) begin
            @(negedge mclk_in);
            guard++;
        end
        run = 1'b0;
        cyc(6);
    endtask

    task automatic start_cnt(input logic [15:0] per, input tcpwm_pkg::tcpwm_run_e m);
        @(negedge mclk_in);
        period_in = per;
        run_mode_in = m;
        start_in = 1'b1;
        @(negedge mclk_in);
        start_in = 1'b0;
        chk(count_out, per);
        chk(running_out, 1'b1);
    endtask

    // ------------------------------------------------------------
    // Scenarios
    // ------------------------------------------------------------
    task automatic t_sources();
        start_cnt(16'h0009, tcpwm_pkg::TCPWM_RUN_FREE);
        for (int s = 0; s < 4; s++) begin
            clk_sel_in = s[1:0];
            line = s[1:0];
            pulse_src(1);
            chk(count_out, 16'h0008 - s[15:0]);
        end
        clk_sel_in = 2'h1;
        pulse_src(2);
        chk(count_out, 16'h0005);
        clk_sel_in = 2'h3;
    endtask

    task automatic t_tc();
        int t0;
        int i0;
        irq_tc_en_in = 1'b1;
        start_cnt(16'h0003, tcpwm_pkg::TCPWM_RUN_FREE);
        t0 = tc_rises;
        i0 = irq_cnt;
        pulse_src(3);
        chk(count_out, 16'h0000);
        chk(tc_out, 1'b1);
        pulse_src(1);
        chk(count_out, 16'h0003);
        chk(tc_out, 1'b0);
        pulse_src(4);
        chk(tc_rises - t0, 16'h0002);
        chk(irq_cnt - i0, 16'h0002);
    endtask

    task automatic t_modes();
        start_cnt(16'h0002, tcpwm_pkg::TCPWM_RUN_ONESHOT);
        pulse_src(2);
        chk(running_out, 1'b0);
        pulse_src(2);
        chk(count_out, 16'h0000);
        start_cnt(16'h0004, tcpwm_pkg::TCPWM_RUN_GATED);
        pulse_src(2);
        chk(count_out, 16'h0004);
        enable_in = 1'b1;
        cyc(4);
        pulse_src(2);
        chk(count_out, 16'h0002);
    endtask

    task automatic t_capture();
        int i0;
        irq_cap_en_in = 1'b1;
        start_cnt(16'h00a5, tcpwm_pkg::TCPWM_RUN_FREE);
        pulse_src(2);
        i0 = irq_cnt;
        capture_in = 1'b1;
        cyc(2);
        capture_in = 1'b0;
        cyc(6);
        chk(capture_val_out, 16'h00a3);
        chk(irq_cnt - i0, 16'h0001);
        chk(count_out, 16'h00a3);
        tmr_reset_in = 1'b1;
        cyc(2);
        tmr_reset_in = 1'b0;
        cyc(6);
        chk(count_out, 16'h00a5);
        chk(running_out, 1'b1);
        stop_in = 1'b1;
        cyc(1);
        stop_in = 1'b0;
        chk(running_out, 1'b0);
    endtask

    // Count parked at 00a5; compare above, equal and below it
    task automatic t_compare();
        logic [15:0] cv [3] = '{16'h00a6, 16'h00a5, 16'h00a4};
        logic [4:0] ex [3] = '{5'b00011, 5'b01110, 5'b11000};
        int n;
        int i0;
        for (int c = 0; c < 3; c++) begin
            for (int m = 0; m < 5; m++) begin
                cmp_mode_in = tcpwm_pkg::tcpwm_cmp_e'(m[2:0]);
                compare_in = cv[c];
                cyc(4);
                chk(cmp_out, ex[c][m]);
            end
        end
        cmp_invert_in = 1'b1;
        cyc(4);
        chk(cmp_out, 1'b0);
        cmp_invert_in = 1'b0;
        cmp_mode_in = tcpwm_pkg::TCPWM_CMP_EQ;
        compare_in = 16'h00a5;
        cyc(10);
        chk({pwm_hi_out, pwm_lo_out}, 2'h2);
        kill_in = 1'b1;
        cyc(5);
        chk({cmp_out, pwm_hi_out, pwm_lo_out}, 3'h0);
        kill_in = 1'b0;
        cyc(10);
        compare_in = 16'h00a6;
        n = 0;
        while (pwm_hi_out === 1'b1 && n < 10) begin
            cyc(1);
            n++;
        end
        n = 0;
        while (pwm_lo_out !== 1'b1 && n < 20) begin
            if (pwm_hi_out === 1'b0) n++;
            cyc(1);
        end
        chk(n, {8'h00, deadband_in} + 16'h0001);
        chk(both_hi, 16'h0000);
        irq_cmp_en_in = 1'b1;
        i0 = irq_cnt;
        compare_in = 16'h00a5;
        cyc(4);
        chk(16'(irq_cnt - i0), 16'h0001);
    endtask

    initial begin
        cyc(5);
        resetn_in = 1'b1;
        cyc(1);
        chk(count_out, 16'h0000);
        chk({13'h0000, running_out, tc_out, irq_out}, 16'h0000);
        t_sources();
        t_tc();
        t_modes();
        t_capture();
        t_compare();
        summarize();
    end
endmodule
